/* scg_regs.sv */
// serializer configuration and pin register bank behind a byte register port
`timescale 1ns/1ns
// What this block does
// - bus address bits 7:1 writable, reset 57 hex, bit 0 reads zero
// - analog power-down bit 4 of reset control disables analog blocks, default zero
// - writing one to reset bit 0 resets all but the bus address and the read data register
// - pin 0 selector: general output, link loss, clock loss, clock detect
// - pin 1 selector: power-on reset, general output, lock, lane losses
// - pin 2 selector: general output, always-on, serializer, digital clocks
// - pull field: none, pulldown, pullup; resets to pulldown
// - bit 1 enables the pin input buffer, resets off
// - bit 0 enables the pin output driver, resets on
// - general-output mode drives the matching bit of register 06
// - register 05 reports sampled pin levels in bits 2:0
module scg_regs (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic      [6:0] bus_address,
	output logic            analog_power_down,
	input  wire logic       link_loss,
	input  wire logic       parallel_clock_los,
	input  wire logic       parallel_clock_detect,
	input  wire logic       power_on_reset,
	input  wire logic       pll_lock,
	input  wire logic [4:0] lane_los,
	input  wire logic       always_on_clock,
	input  wire logic       serializer_clock,
	input  wire logic       digital_clock,
	input  wire logic [2:0] pin_in,
	output logic      [2:0] pin_out,
	output logic      [2:0] pin_oe_n,
	output logic      [2:0] pin_pullup_en,
	output logic      [2:0] pin_pulldown_en
);
	scg_cfg_if cfg ();

	logic [6:0] bus_address_ff, nxt_bus_address;
	logic       analog_off_ff, nxt_analog_off;
	logic       soft_reset_ff, nxt_soft_reset;
	logic [7:0] pin_cfg_ff [3];
	logic [7:0] nxt_pin_cfg [3];
	logic [2:0] gen_out_ff, nxt_gen_out;
	logic [7:0] rdata_ff, nxt_rdata;
	logic       bank_rst;

	// software reset pulse clears the bank one cycle after the write
	assign bank_rst = rst | soft_reset_ff;

	// bus address only follows the hard reset
	always_comb begin
		nxt_bus_address = bus_address_ff;
		if (reg_wr && reg_addr == scg_pkg::ADDR_BUS_ADDRESS) begin
			nxt_bus_address = reg_wdata[7:1];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_address_ff <= scg_pkg::RST_BUS_ADDRESS;
		end else begin
			bus_address_ff <= nxt_bus_address;
		end
	end

	// reset control and pin bank writes
	always_comb begin
		nxt_analog_off = analog_off_ff;
		nxt_soft_reset = 1'b0; // self clearing
		nxt_gen_out    = gen_out_ff;
		for (int i = 0; i < 3; i++) begin
			nxt_pin_cfg[i] = pin_cfg_ff[i];
		end
		if (reg_wr) begin
			case (reg_addr)
				scg_pkg::ADDR_RESET_CTRL: begin
					nxt_analog_off = reg_wdata[scg_pkg::BIT_ANALOG_OFF];
					nxt_soft_reset = reg_wdata[scg_pkg::BIT_SOFT_RESET];
				end
				scg_pkg::ADDR_PIN0_CFG: nxt_pin_cfg[0] = reg_wdata;
				scg_pkg::ADDR_PIN1_CFG: nxt_pin_cfg[1] = reg_wdata;
				scg_pkg::ADDR_PIN2_CFG: nxt_pin_cfg[2] = reg_wdata;
				scg_pkg::ADDR_GEN_OUTPUT: nxt_gen_out = reg_wdata[2:0];
				default: nxt_gen_out = gen_out_ff;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (bank_rst) begin
			analog_off_ff <= 1'b0;
			soft_reset_ff <= 1'b0;
			gen_out_ff    <= '0;
			for (int i = 0; i < 3; i++) begin
				pin_cfg_ff[i] <= scg_pkg::RST_PIN_CFG;
			end
		end else begin
			analog_off_ff <= nxt_analog_off;
			soft_reset_ff <= nxt_soft_reset;
			gen_out_ff    <= nxt_gen_out;
			for (int i = 0; i < 3; i++) begin
				pin_cfg_ff[i] <= nxt_pin_cfg[i];
			end
		end
	end

	// read mux, reserved bits read zero, unmapped reads zero
	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_rd) begin
			case (reg_addr)
				scg_pkg::ADDR_BUS_ADDRESS: nxt_rdata = {bus_address_ff, 1'b0};
				scg_pkg::ADDR_RESET_CTRL:  nxt_rdata = {3'h0, analog_off_ff, 3'h0,
					soft_reset_ff};
				scg_pkg::ADDR_PIN0_CFG:    nxt_rdata = pin_cfg_ff[0];
				scg_pkg::ADDR_PIN1_CFG:    nxt_rdata = pin_cfg_ff[1];
				scg_pkg::ADDR_PIN2_CFG:    nxt_rdata = pin_cfg_ff[2];
				scg_pkg::ADDR_GEN_INPUT:   nxt_rdata = {5'h0, cfg.pin_sampled};
				scg_pkg::ADDR_GEN_OUTPUT:  nxt_rdata = {5'h0, gen_out_ff};
				default:                   nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// fan the config fields out to the pin logic
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_cfg
			assign cfg.pin_function_select[g] = pin_cfg_ff[g][scg_pkg::SEL_HI:scg_pkg::SEL_LO];
			assign cfg.pin_pull_select[g]     = pin_cfg_ff[g][scg_pkg::PULL_HI:scg_pkg::PULL_LO];
			assign cfg.input_enable[g]        = pin_cfg_ff[g][scg_pkg::BIT_IN_EN];
			assign cfg.output_enable[g]       = pin_cfg_ff[g][scg_pkg::BIT_OUT_EN];
		end
	endgenerate
	assign cfg.general_output_value = gen_out_ff;
	assign cfg.pin_value            = pin_in;

	scg_pin_mux u_pins (
		.clk_sys               (clk_sys),
		.rst                   (bank_rst),
		.cfg                   (cfg),
		.link_loss             (link_loss),
		.parallel_clock_los    (parallel_clock_los),
		.parallel_clock_detect (parallel_clock_detect),
		.power_on_reset        (power_on_reset),
		.pll_lock              (pll_lock),
		.lane_los              (lane_los),
		.always_on_clock       (always_on_clock),
		.serializer_clock      (serializer_clock),
		.digital_clock         (digital_clock),
		.pin_out               (pin_out),
		.pin_oe_n              (pin_oe_n),
		.pin_pullup_en         (pin_pullup_en),
		.pin_pulldown_en       (pin_pulldown_en)
	);

	assign reg_rdata         = rdata_ff;
	assign bus_address       = bus_address_ff;
	assign analog_power_down = analog_off_ff;
endmodule

/* scg_pkg.sv */
// shared constants for the serializer config and pin register bank
package scg_pkg;
	localparam int          NUM_PINS        = 3;
	localparam logic [7:0]  ADDR_BUS_ADDRESS = 8'h00;
	localparam logic [7:0]  ADDR_RESET_CTRL  = 8'h01;
	localparam logic [7:0]  ADDR_PIN0_CFG    = 8'h02;
	localparam logic [7:0]  ADDR_PIN1_CFG    = 8'h03;
	localparam logic [7:0]  ADDR_PIN2_CFG    = 8'h04;
	localparam logic [7:0]  ADDR_GEN_INPUT   = 8'h05;
	localparam logic [7:0]  ADDR_GEN_OUTPUT  = 8'h06;
	localparam logic [6:0]  RST_BUS_ADDRESS  = 7'h57;
	localparam int          BIT_ANALOG_OFF   = 4;
	localparam int          BIT_SOFT_RESET   = 0;
	localparam logic [7:0]  RST_PIN_CFG      = 8'h05;
	localparam int          SEL_HI           = 7;
	localparam int          SEL_LO           = 4;
	localparam int          PULL_HI          = 3;
	localparam int          PULL_LO          = 2;
	localparam int          BIT_IN_EN        = 1;
	localparam int          BIT_OUT_EN       = 0;
	localparam logic [1:0]  PULL_NONE        = 2'h0;
	localparam logic [1:0]  PULL_DOWN        = 2'h1;
	localparam logic [1:0]  PULL_UP          = 2'h2;
	localparam logic [3:0]  P0_GEN_OUT       = 4'h0;
	localparam logic [3:0]  P0_LINK_LOSS     = 4'h1;
	localparam logic [3:0]  P0_CLK_LOS       = 4'h3;
	localparam logic [3:0]  P0_CLK_DET       = 4'h4;
	localparam logic [3:0]  P1_POR           = 4'h0;
	localparam logic [3:0]  P1_GEN_OUT       = 4'h1;
	localparam logic [3:0]  P1_PLL_LOCK      = 4'h2;
	localparam logic [3:0]  P1_LANE0_LOS     = 4'h3;
	localparam logic [3:0]  P1_LANE4_LOS     = 4'h7;
	localparam logic [3:0]  P2_GEN_OUT       = 4'h0;
	localparam logic [3:0]  P2_ALWAYS_CLK    = 4'h1;
	localparam logic [3:0]  P2_SER_CLK       = 4'h2;
	localparam logic [3:0]  P2_DIG_CLK       = 4'h4;
endpackage

/* scg_cfg_if.sv */
// per-pin configuration carried from the register bank to the pin muxes
`timescale 1ns/1ns
interface scg_cfg_if;
	logic [3:0] pin_function_select [3];
	logic [1:0] pin_pull_select     [3];
	logic [2:0] input_enable;
	logic [2:0] output_enable;
	logic [2:0] general_output_value;
	logic [2:0] pin_value;
	logic [2:0] pin_sampled;
	modport regs (output pin_function_select, output pin_pull_select, output input_enable,
		output output_enable, output general_output_value, input pin_sampled);
	modport pins (input pin_function_select, input pin_pull_select, input input_enable,
		input output_enable, input general_output_value, input pin_value,
		output pin_sampled);
endinterface

/* scg_pin_sync.sv */
// three-stage synchroniser with agreement filter for the pin inputs
`timescale 1ns/1ns
module scg_pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
	logic [WIDTH-1:0] nxt_out;

	// take a new level only once stages two and three agree
	always_comb begin
		nxt_out = out_ff;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_out[i] = s3_ff[i];
			end
		end
	end

	// register the chain
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			out_ff <= '0;
		end else begin
			s1_ff  <= async_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign sync_out = out_ff;
endmodule

/* scg_pin_mux.sv */
// pin function muxes, pad controls and input sampling
`timescale 1ns/1ns
module scg_pin_mux (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	scg_cfg_if.pins         cfg,
	input  wire logic       link_loss,
	input  wire logic       parallel_clock_los,
	input  wire logic       parallel_clock_detect,
	input  wire logic       power_on_reset,
	input  wire logic       pll_lock,
	input  wire logic [4:0] lane_los,
	input  wire logic       always_on_clock,
	input  wire logic       serializer_clock,
	input  wire logic       digital_clock,
	output logic      [2:0] pin_out,
	output logic      [2:0] pin_oe_n,
	output logic      [2:0] pin_pullup_en,
	output logic      [2:0] pin_pulldown_en
);
	logic [2:0] sel_val;
	logic [2:0] pin_sync;
	logic [2:0] pin_out_ff, nxt_pin_out;

	// pin 0 source select
	always_comb begin
		case (cfg.pin_function_select[0])
			scg_pkg::P0_GEN_OUT:   sel_val[0] = cfg.general_output_value[0];
			scg_pkg::P0_LINK_LOSS: sel_val[0] = link_loss;
			scg_pkg::P0_CLK_LOS:   sel_val[0] = parallel_clock_los;
			scg_pkg::P0_CLK_DET:   sel_val[0] = parallel_clock_detect;
			default:               sel_val[0] = 1'b0;
		endcase
	end

	// pin 1 source select, lane loss codes are consecutive
	always_comb begin
		case (cfg.pin_function_select[1])
			scg_pkg::P1_POR:      sel_val[1] = power_on_reset;
			scg_pkg::P1_GEN_OUT:  sel_val[1] = cfg.general_output_value[1];
			scg_pkg::P1_PLL_LOCK: sel_val[1] = pll_lock;
			default: begin
				if (cfg.pin_function_select[1] >= scg_pkg::P1_LANE0_LOS &&
					cfg.pin_function_select[1] <= scg_pkg::P1_LANE4_LOS) begin
					sel_val[1] = lane_los[3'(cfg.pin_function_select[1] -
						scg_pkg::P1_LANE0_LOS)];
				end else begin
					sel_val[1] = 1'b0;
				end
			end
		endcase
	end

	// pin 2 source select; clocks pass combinationally
	always_comb begin
		case (cfg.pin_function_select[2])
			scg_pkg::P2_GEN_OUT:    sel_val[2] = cfg.general_output_value[2];
			scg_pkg::P2_ALWAYS_CLK: sel_val[2] = always_on_clock;
			scg_pkg::P2_SER_CLK:    sel_val[2] = serializer_clock;
			scg_pkg::P2_DIG_CLK:    sel_val[2] = digital_clock;
			default:                sel_val[2] = 1'b0;
		endcase
	end

	// status outputs registered; clock sources bypass the flop
	always_comb begin
		nxt_pin_out = sel_val;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_out_ff <= '0;
		end else begin
			pin_out_ff <= nxt_pin_out;
		end
	end

	// pad controls per pin
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_pad
			assign pin_oe_n[g]        = ~cfg.output_enable[g];
			assign pin_pulldown_en[g] = (cfg.pin_pull_select[g] == scg_pkg::PULL_DOWN);
			assign pin_pullup_en[g]   = (cfg.pin_pull_select[g] == scg_pkg::PULL_UP);
			assign cfg.pin_sampled[g] = cfg.input_enable[g] & pin_sync[g];
		end
	endgenerate

	assign pin_out = {(cfg.pin_function_select[2] == scg_pkg::P2_GEN_OUT) ? pin_out_ff[2]
		: sel_val[2], pin_out_ff[1:0]};

	scg_pin_sync #(.WIDTH(3)) u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in (cfg.pin_value),
		.sync_out (pin_sync)
	);
endmodule

/* scg_regs_asserts.sv */
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module scg_regs_asserts (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [6:0] bus_address,
	input wire logic       analog_power_down,
	input wire logic [2:0] pin_oe_n,
	input wire logic [2:0] pin_pullup_en,
	input wire logic [2:0] pin_pulldown_en
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// pin 0 pad controls follow a config write at the next edge
	property p_pin0_cfg;
		logic [7:0] w;
		(reg_wr && reg_addr == 8'h02, w = reg_wdata) |=>
			(pin_oe_n[0] == !w[0] && pin_pullup_en[0] == (w[3:2] == 2'h2)
			&& pin_pulldown_en[0] == (w[3:2] == 2'h1));
	endproperty
	a_rst_defaults: assert property ($fell(rst) |-> bus_address == 7'h57
		&& !analog_power_down && pin_oe_n == 3'h0 && pin_pulldown_en == 3'h7)
		else $error("reset defaults wrong");
	a_addr_write: assert property (reg_wr && reg_addr == 8'h00 |=>
		bus_address == $past(reg_wdata[7:1])) else $error("bus address not written");
	a_power_down: assert property (reg_wr && reg_addr == 8'h01 && !reg_wdata[0] |=>
		analog_power_down == $past(reg_wdata[4])) else $error("power down wrong");
	a_soft_reset: assert property (reg_wr && reg_addr == 8'h01 && reg_wdata[0] |=>
		##1 (!analog_power_down && $stable(bus_address) && pin_oe_n == 3'h0))
		else $error("soft reset wrong");
	a_pin0_cfg: assert property (p_pin0_cfg) else $error("pin 0 pad control wrong");
	a_addr_read: assert property (reg_rd && !reg_wr && reg_addr == 8'h00 |=>
		reg_rdata == {bus_address, 1'b0}) else $error("address readback wrong");
	a_rsvd_bits: assert property (reg_rd && reg_addr == 8'h01 |=>
		reg_rdata[7:5] == 3'h0 && reg_rdata[3:1] == 3'h0) else $error("reserved bits set");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h06 |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	c_soft: cover property (reg_wr && reg_addr == 8'h01 && reg_wdata[0]);
	c_addr: cover property (reg_wr && reg_addr == 8'h00);
	c_read: cover property (reg_rd && reg_addr == 8'h05);
endmodule

/* scg_host_model.sv */
// host side of the byte register port
`timescale 1ns/1ns
module scg_host_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// strobe held across one rising edge; normal traffic avoids reserved places
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_addr = ~a; // released lines show a changed pattern
		reg_wdata = ~d;
	endtask
	// read answer is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

/* tb_top.sv */
// self-checking bench for the config and pin register bank
`timescale 1ns/1ns
module tb_top;
	logic       clk_sys, rst, reg_wr, reg_rd, analog_power_down;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic [6:0] bus_address;
	logic       link_loss, parallel_clock_los, parallel_clock_detect, power_on_reset;
	logic       pll_lock, always_on_clock, serializer_clock, digital_clock;
	logic [4:0] lane_los;
	logic [2:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_pulldown_en;
	int         fail_count = 0;
	int         cmp_count = 0;
	// pin, selector code, expected level in bit 0 (bit 1 marks a reserved code)
	logic [11:0] mt [18] = '{12'h001, 12'h011, 12'h030, 12'h041, 12'h022, 12'h101,
		12'h110, 12'h120, 12'h130, 12'h141, 12'h150, 12'h161, 12'h170, 12'h201,
		12'h211, 12'h220, 12'h241, 12'h232};
	scg_regs scg_regs_inst (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .bus_address, .analog_power_down, .link_loss, .parallel_clock_los,
		.parallel_clock_detect, .power_on_reset, .pll_lock, .lane_los, .always_on_clock,
		.serializer_clock, .digital_clock, .pin_in, .pin_out, .pin_oe_n, .pin_pullup_en,
		.pin_pulldown_en);
	scg_host_model scg_host_model_inst (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd);
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		scg_host_model_inst.rd(a, rv);
		chk("register", rv, e);
	endtask
	task automatic results();
		if (fail_count == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// reset values of every mapped register and pad control
	task automatic t_defaults();
		logic [7:0] d [7] = '{8'hae, 8'h00, 8'h05, 8'h05, 8'h05, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) rchk(8'(i), d[i]);
		chk("bus_address", {1'b0, bus_address}, 8'h57);
		chk("pulls", {pin_pullup_en, pin_pulldown_en}, 8'h07);
		chk("oe_n", {5'h0, pin_oe_n}, 8'h00);
	endtask
	// every pull code on pin 2, read back as written
	task automatic t_pull();
		for (int c = 0; c < 4; c++) begin
			scg_host_model_inst.wr(8'h04, {4'h0, 2'(c), 2'h1});
			repeat (2) @(negedge clk_sys);
			chk("pullup", {7'h0, pin_pullup_en[2]}, {7'h0, c == 2});
			chk("pulldown", {7'h0, pin_pulldown_en[2]}, {7'h0, c == 1});
			rchk(8'h04, {4'h0, 2'(c), 2'h1});
		end
	endtask
	// every defined selector code of every pin plus one reserved code on pins 0 and 2, then again with every source level inverted
	task automatic t_modes();
		logic e;
		for (int p = 0; p < 2; p++) begin
			scg_host_model_inst.wr(8'h06, (p == 0) ? 8'h05 : 8'h02);
			for (int i = 0; i < 18; i++) begin
				scg_host_model_inst.wr(8'h02 + 8'(mt[i][11:8]), {mt[i][7:4], 4'h5});
				repeat (2) @(negedge clk_sys);
				e = mt[i][0] ^ (p == 1 && !mt[i][1]); // reserved codes stay low
				chk("pin_out", {7'h0, pin_out[mt[i][9:8]]}, {7'h0, e});
			end
			rchk(8'h06, (p == 0) ? 8'h05 : 8'h02);
			{link_loss, parallel_clock_los, parallel_clock_detect, power_on_reset} = 4'h4;
			{pll_lock, always_on_clock, serializer_clock, digital_clock} = 4'ha;
			lane_los = 5'h15;
		end
	endtask
	// sampled pin levels, with and without the input buffer
	task automatic t_input();
		for (int p = 0; p < 3; p++) scg_host_model_inst.wr(8'h02 + 8'(p), 8'h06);
		pin_in = 3'h5;
		repeat (8) @(negedge clk_sys);
		rchk(8'h05, 8'h05);
		chk("oe_n", {5'h0, pin_oe_n}, 8'h07);
		scg_host_model_inst.wr(8'h02, 8'h04);
		repeat (8) @(negedge clk_sys);
		rchk(8'h05, 8'h04);
	endtask
	// power down, address write, refused places, then software reset
	task automatic t_soft();
		scg_host_model_inst.wr(8'h01, 8'h10);
		chk("power_down", {7'h0, analog_power_down}, 8'h01);
		rchk(8'h01, 8'h10);
		scg_host_model_inst.wr(8'h00, 8'hfe);
		rchk(8'h00, 8'hfe);
		rchk(8'h07, 8'h00);
		scg_host_model_inst.wr(8'h01, 8'h11);
		repeat (2) @(negedge clk_sys);
		chk("power_down", {7'h0, analog_power_down}, 8'h00);
		chk("bus_address", {1'b0, bus_address}, 8'h7f);
		rchk(8'h01, 8'h00);
		rchk(8'h04, 8'h05);
		rchk(8'h06, 8'h00);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		results();
	end
	initial begin
		rst = 1'b1;
		{link_loss, parallel_clock_los, parallel_clock_detect, power_on_reset} = 4'hb;
		{pll_lock, always_on_clock, serializer_clock, digital_clock} = 4'h5;
		lane_los = 5'h0a;
		pin_in = 3'h0;
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		t_defaults();
		t_pull();
		t_modes();
		t_input();
		t_soft();
		results();
	end
endmodule
bind scg_regs scg_regs_asserts scg_regs_asserts_inst (.clk_sys, .rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_address, .analog_power_down,
	.pin_oe_n, .pin_pullup_en, .pin_pulldown_en);
